/* rtl/prsp_target.sv */
// Two-wire read-only target port of a pressure and temperature sensor.
// Assumes SCL/SDA are asynchronous; measurements arrive on i_clk side.
//
// Notes on behaviour
// - Both lines high means bus idle.
// - SDA falls with SCL high: start.
// - SDA rises with SCL high: stop, idle.
// - Repeated start restarts the address phase.
// - Change SDA only while SCL low.
// - Transfers are whole eight-bit bytes.
// - Most significant bit goes first.
// - Target may stretch SCL low when unready.
// - Receiver acknowledges every byte; this target acknowledges only its own read address.
// - Sender releases SDA on ninth pulse.
// - Acknowledge is SDA low whole high phase.
// - High on ninth pulse means refusal.
// - First byte: seven-bit address plus direction.
// - Answer only address 0x78.
// - Direction zero write, one read.
// - Transmit only; no write path.
// - Acknowledge own read address, then stream.
// - Send pressure then temperature, high first.
// - Each value is fifteen bits in two bytes.
// - Refresh the result pair every 2.2 ms.
// - Alternate values while host keeps acknowledging.
`timescale 1ns/1ps
module prsp_target #(
	parameter int REFRESH_CYC = prsp_pkg::PRSP_REFRESH_CYC
) (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	// Measurement engine
	input  wire logic [14:0] i_pressure,
	input  wire logic [14:0] i_temperature,
	// Bus pins
	input  wire logic        i_scl,
	output logic             o_scl,
	output logic             o_scl_oe,
	input  wire logic        i_sda,
	output logic             o_sda,
	output logic             o_sda_oe,
	// Status
	output logic             o_busy,
	output logic             o_selected,
	output logic             o_sample_tick
);

	// ------------------------------------------------------------
	// Line conditioning
	// ------------------------------------------------------------
	logic scl_f;
	logic sda_f;

	prsp_line_filt u_scl_filt (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_line   (i_scl),
		.o_level  (scl_f)
	);

	prsp_line_filt u_sda_filt (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_line   (i_sda),
		.o_level  (sda_f)
	);

	logic scl_d_r;
	logic sda_d_r;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;

	assign scl_rise   = scl_f & ~scl_d_r;
	assign scl_fall   = ~scl_f & scl_d_r;
	assign start_cond = scl_f & scl_d_r & sda_d_r & ~sda_f;
	assign stop_cond  = scl_f & scl_d_r & ~sda_d_r & sda_f;

	// ------------------------------------------------------------
	// Measurement refresh
	// ------------------------------------------------------------
	logic [31:0] tick_cnt_r;
	logic [31:0] tick_cnt_nxt;
	logic        tick_nxt;
	logic [14:0] press_r;
	logic [14:0] press_nxt;
	logic [14:0] temp_r;
	logic [14:0] temp_nxt;

	always_comb begin
		tick_cnt_nxt = tick_cnt_r + 32'h1;
		tick_nxt     = 1'b0;
		press_nxt    = press_r;
		temp_nxt     = temp_r;
		if (tick_cnt_r == 32'(REFRESH_CYC - 1)) begin
			tick_cnt_nxt = 32'h0;
			tick_nxt     = 1'b1;
			press_nxt    = i_pressure;
			temp_nxt     = i_temperature;
		end
	end

	// ------------------------------------------------------------
	// Protocol engine
	// ------------------------------------------------------------
	prsp_pkg::prsp_state_t state_r;
	prsp_pkg::prsp_state_t state_nxt;
	logic [3:0]            bit_r;
	logic [3:0]            bit_nxt;
	logic [7:0]            shift_r;
	logic [7:0]            shift_nxt;
	logic [1:0]            idx_r;
	logic [1:0]            idx_nxt;
	logic [15:0]           snap_p_r;
	logic [15:0]           snap_p_nxt;
	logic [15:0]           snap_t_r;
	logic [15:0]           snap_t_nxt;
	logic                  sda_oe_nxt;
	logic                  busy_nxt;
	logic                  sel_nxt;
	logic [7:0]            pick_nxt;

	// Byte selector for the pressure/temperature stream
	function automatic logic [7:0] pick_byte(input logic [1:0]  idx,
	                                         input logic [15:0] p,
	                                         input logic [15:0] t);
		case (idx)
			prsp_pkg::PRSP_BYTE_PH: pick_byte = p[15:8];
			prsp_pkg::PRSP_BYTE_PL: pick_byte = p[7:0];
			prsp_pkg::PRSP_BYTE_TH: pick_byte = t[15:8];
			default:                pick_byte = t[7:0];
		endcase
	endfunction

	assign pick_nxt = pick_byte(idx_r, snap_p_r, snap_t_r);

	always_comb begin
		state_nxt  = state_r;
		bit_nxt    = bit_r;
		shift_nxt  = shift_r;
		idx_nxt    = idx_r;
		snap_p_nxt = snap_p_r;
		snap_t_nxt = snap_t_r;
		sda_oe_nxt = o_sda_oe;
		busy_nxt   = o_busy;
		sel_nxt    = o_selected;
		if (start_cond) begin
			state_nxt  = prsp_pkg::PRSP_ADDR;
			bit_nxt    = 4'h0;
			sda_oe_nxt = 1'b1;
			busy_nxt   = 1'b1;
			sel_nxt    = 1'b0;
		end else if (stop_cond || (scl_f && sda_f && state_r == prsp_pkg::PRSP_IDLE)) begin
			state_nxt  = prsp_pkg::PRSP_IDLE;
			sda_oe_nxt = 1'b1;
			busy_nxt   = stop_cond ? 1'b0 : o_busy;
			if (stop_cond)
				sel_nxt = 1'b0;
		end else begin
			case (state_r)
				prsp_pkg::PRSP_IDLE: begin
					sda_oe_nxt = 1'b1;
				end
				prsp_pkg::PRSP_ADDR: begin
					if (scl_rise) begin
						shift_nxt = {shift_r[6:0], sda_f};
						bit_nxt   = bit_r + 4'h1;
					end else if (scl_fall && bit_r == prsp_pkg::PRSP_BIT_ACK) begin
						if (shift_r[7:1] == prsp_pkg::PRSP_OWN_ADDR &&
						    shift_r[0] == prsp_pkg::PRSP_DIR_READ) begin
							state_nxt  = prsp_pkg::PRSP_AACK;
							sda_oe_nxt = 1'b0;
							sel_nxt    = 1'b1;
						end else begin
							state_nxt = prsp_pkg::PRSP_WAIT;
						end
					end
				end
				prsp_pkg::PRSP_AACK: begin
					// Snapshot keeps the four bytes of one pair coherent
					if (scl_fall) begin
						snap_p_nxt = {1'b0, press_r};
						snap_t_nxt = {1'b0, temp_r};
						idx_nxt    = prsp_pkg::PRSP_BYTE_PH;
						shift_nxt  = {1'b0, press_r[14:8]};
						bit_nxt    = 4'h0;
						// Top bit of a high byte is zero, so keep pulling low
						sda_oe_nxt = 1'b0;
						state_nxt  = prsp_pkg::PRSP_SEND;
					end
				end
				prsp_pkg::PRSP_SEND: begin
					sda_oe_nxt = shift_r[7];
					if (scl_fall) begin
						if (bit_r == prsp_pkg::PRSP_BIT_LAST) begin
							sda_oe_nxt = 1'b1;
							state_nxt  = prsp_pkg::PRSP_MACK;
						end else begin
							shift_nxt  = {shift_r[6:0], 1'b0};
							sda_oe_nxt = shift_r[6];
						end
						bit_nxt = bit_r + 4'h1;
					end
				end
				prsp_pkg::PRSP_MACK: begin
					sda_oe_nxt = 1'b1;
					if (scl_rise) begin
						if (sda_f) begin
							state_nxt = prsp_pkg::PRSP_WAIT;
						end else begin
							idx_nxt = idx_r + 2'h1;
						end
					end else if (scl_fall) begin
						shift_nxt  = pick_nxt;
						bit_nxt    = 4'h0;
						state_nxt  = prsp_pkg::PRSP_SEND;
						sda_oe_nxt = pick_nxt[7];
						if (idx_r == prsp_pkg::PRSP_BYTE_PH) begin
							// New pair at each wrap picks up fresh results
							snap_p_nxt = {1'b0, press_r};
							snap_t_nxt = {1'b0, temp_r};
							shift_nxt  = {1'b0, press_r[14:8]};
							sda_oe_nxt = 1'b0;
						end
					end
				end
				prsp_pkg::PRSP_WAIT: begin
					sda_oe_nxt = 1'b1;
				end
				default: begin
					state_nxt  = prsp_pkg::PRSP_IDLE;
					sda_oe_nxt = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			scl_d_r       <= 1'b1;
			sda_d_r       <= 1'b1;
			tick_cnt_r    <= 32'h0;
			o_sample_tick <= 1'b0;
			press_r       <= 15'h0;
			temp_r        <= 15'h0;
			state_r       <= prsp_pkg::PRSP_IDLE;
			bit_r         <= 4'h0;
			shift_r       <= 8'h0;
			idx_r         <= 2'h0;
			snap_p_r      <= 16'h0;
			snap_t_r      <= 16'h0;
			o_sda_oe      <= 1'b1;
			o_busy        <= 1'b0;
			o_selected    <= 1'b0;
		end else begin
			scl_d_r       <= scl_f;
			sda_d_r       <= sda_f;
			tick_cnt_r    <= tick_cnt_nxt;
			o_sample_tick <= tick_nxt;
			press_r       <= press_nxt;
			temp_r        <= temp_nxt;
			state_r       <= state_nxt;
			bit_r         <= bit_nxt;
			shift_r       <= shift_nxt;
			idx_r         <= idx_nxt;
			snap_p_r      <= snap_p_nxt;
			snap_t_r      <= snap_t_nxt;
			o_sda_oe      <= sda_oe_nxt;
			o_busy        <= busy_nxt;
			o_selected    <= sel_nxt;
		end
	end

	// ------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------
	logic scl_oe_nxt;
	logic scl_drv_nxt;
	logic sda_drv_nxt;

	// Data is always ready in the snapshot, so SCL is never stretched
	// Pins only ever pull low; the enables decide whether they do
	always_comb begin
		scl_oe_nxt  = 1'b1;
		scl_drv_nxt = 1'b0;
		sda_drv_nxt = 1'b0;
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_scl    <= 1'b0;
			o_scl_oe <= 1'b1;
			o_sda    <= 1'b0;
		end else begin
			o_scl    <= scl_drv_nxt;
			o_scl_oe <= scl_oe_nxt;
			o_sda    <= sda_drv_nxt;
		end
	end

endmodule // prsp_target

/* rtl/prsp_pkg.sv */
// Shared constants for the read-only sensor two-wire target port.
// Assumes a 250 MHz system clock; bus lines arrive asynchronously.
package prsp_pkg;

	// ------------------------------------------------------------
	// Addressing
	// ------------------------------------------------------------
	localparam logic [6:0] PRSP_OWN_ADDR    = 7'h78;
	localparam logic       PRSP_DIR_READ    = 1'b1;

	// ------------------------------------------------------------
	// Byte format
	// ------------------------------------------------------------
	localparam int         PRSP_BYTE_BITS   = 8;
	localparam logic [3:0] PRSP_BIT_LAST    = 4'h7;
	localparam logic [3:0] PRSP_BIT_ACK     = 4'h8;
	localparam int         PRSP_VAL_BITS    = 15;
	localparam logic [1:0] PRSP_BYTE_PH     = 2'h0;
	localparam logic [1:0] PRSP_BYTE_PL     = 2'h1;
	localparam logic [1:0] PRSP_BYTE_TH     = 2'h2;
	localparam logic [1:0] PRSP_BYTE_TL     = 2'h3;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int         PRSP_CLK_MHZ     = 250;
	localparam int         PRSP_REFRESH_NS  = 2200000;
	localparam int         PRSP_REFRESH_CYC = PRSP_REFRESH_NS * PRSP_CLK_MHZ / 1000;
	localparam int         PRSP_FILT_LEN    = 3;

	// ------------------------------------------------------------
	// Protocol states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		PRSP_IDLE  = 3'b000,
		PRSP_ADDR  = 3'b001,
		PRSP_AACK  = 3'b010,
		PRSP_SEND  = 3'b011,
		PRSP_MACK  = 3'b100,
		PRSP_WAIT  = 3'b101
	} prsp_state_t;

endpackage

/* rtl/prsp_line_filt.sv */
// Two-flop synchroniser and three-sample agreement glitch filter for one bus line.
// Input is asynchronous; output is a clean level in the i_clk domain.
`timescale 1ns/1ps
module prsp_line_filt (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_resetn,
	// Line
	input  wire logic i_line,
	output logic      o_level
);

	logic [1:0]                          sync_r;
	logic [prsp_pkg::PRSP_FILT_LEN-1:0]  hist_r;
	logic [prsp_pkg::PRSP_FILT_LEN-1:0]  hist_nxt;
	logic                                level_r;
	logic                                level_nxt;

	always_comb begin
		hist_nxt  = {hist_r[prsp_pkg::PRSP_FILT_LEN-2:0], sync_r[1]};
		level_nxt = level_r;
		if (&hist_r)
			level_nxt = 1'b1;
		else if (~|hist_r)
			level_nxt = 1'b0;
	end

	// Idle bus rests high, so reset to high
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sync_r  <= 2'h3;
			hist_r  <= '1;
			level_r <= 1'b1;
		end else begin
			sync_r  <= {sync_r[0], i_line};
			hist_r  <= hist_nxt;
			level_r <= level_nxt;
		end
	end

	assign o_level = level_r;

endmodule // prsp_line_filt

/* tb/prsp_target_asserts.sv */
// Concurrent checks on the pins of the two-wire target port.
// Bound to prsp_target from the bench; sees only its ports.
`timescale 1ns/1ps
module prsp_target_asserts (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic o_scl_oe,
	input wire logic o_sda,
	input wire logic o_sda_oe,
	input wire logic o_busy,
	input wire logic o_selected,
	input wire logic o_sample_tick
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	// Filter latency is about six clocks, so twelve leaves margin
	sequence start_s; i_scl && $fell(i_sda); endsequence
	sequence stop_s; i_scl && $rose(i_sda); endsequence
	scl_free_a: assert property (o_scl_oe) else $error("scl pulled");
	sda_low_a: assert property (!o_sda_oe |-> !o_sda) else $error("sda driven high");
	idle_quiet_a: assert property (!o_busy |-> o_sda_oe && !o_selected)
		else $error("drive while idle");
	sda_move_a: assert property ($changed(o_sda_oe) |-> !i_scl)
		else $error("sda moved with scl high");
	start_busy_a: assert property (start_s |-> ##[1:12] o_busy) else $error("no busy");
	stop_free_a: assert property (stop_s |-> ##[1:12] !o_busy) else $error("still busy");
	rstart_drop_a: assert property (
		o_busy ##0 start_s |-> ##[1:12] (o_busy && !o_selected))
		else $error("repeated start ignored");
	sel_ack_a: assert property ($rose(o_selected) |-> !o_sda_oe) else $error("no ack");
	tick_pulse_a: assert property (o_sample_tick |=> (!o_sample_tick)[*8])
		else $error("tick too close");
endmodule // prsp_target_asserts

/* tb/prsp_host_model.sv */
// Behavioural two-wire bus host driving the target port.
// Open-drain: the bench ANDs host and target pulls, pull-up gives high.
`timescale 1ns/1ps
module prsp_host_model (
	input  wire logic i_clk,
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda
);
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	// Also serves as repeated start when entered with SCL low
	task automatic start();
		o_sda = 1'b1;
		wt(10);
		o_scl = 1'b1;
		wt(10);
		o_sda = 1'b0;
		wt(10);
		o_scl = 1'b0;
	endtask
	task automatic stop();
		wt(10);
		o_sda = 1'b0;
		wt(10);
		o_scl = 1'b1;
		wt(10);
		o_sda = 1'b1;
		wt(20);
	endtask
	// Eight bits then the ninth pulse; 160 ns per pulse
	task automatic xfer(input logic [7:0] tx, input logic ak, output logic [7:0] rx,
		output logic ka);
		logic r;
		for (int i = 8; i >= 0; i--) begin
			wt(10);
			o_sda = (i == 0) ? ak : tx[i-1];
			wt(10);
			o_scl = 1'b1;
			wt(10);
			r = i_sda;
			wt(10);
			o_scl = 1'b0;
			if (i > 0) rx[i-1] = r;
			else ka = r;
		end
	endtask
endmodule // prsp_host_model

/* tb/testbench.sv */
// Self-checking bench: host model reads the target port.
// Refresh shortened to 50 cycles; results held steady during reads.
`timescale 1ns/1ps
module testbench;
	localparam int RC = 50;
	logic        i_clk = 1'b0;
	logic        i_resetn = 1'b0;
	logic [14:0] p = 15'h0000;
	logic [14:0] t = 15'h0000;
	logic        hscl, hsda, o_scl, o_scl_oe, o_sda, o_sda_oe, o_busy, o_selected, tick;
	wire         scl = hscl & (o_scl_oe | o_scl);
	wire         sda = hsda & (o_sda_oe | o_sda);
	int          n_errors = 0;
	int          n_compared = 0;
	int          cyc = 0;
	logic [31:0] lf = 32'h00012FBC;
	logic [7:0]  rx;
	logic        ka;
	logic [7:0]  q[$];
	always #2 i_clk = ~i_clk;
	prsp_target #(.REFRESH_CYC(RC)) prsp_target_inst (.i_clk, .i_resetn, .i_pressure(p),
		.i_temperature(t), .i_scl(scl), .o_scl, .o_scl_oe, .i_sda(sda), .o_sda, .o_sda_oe,
		.o_busy, .o_selected, .o_sample_tick(tick));
	prsp_host_model prsp_host_model_inst (.i_clk, .i_sda(sda), .o_scl(hscl), .o_sda(hsda));
	task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic finish_test();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Own read address, n bytes, host refuses the last
	task automatic rd(input int n);
		logic [15:0] v;
		prsp_host_model_inst.start();
		prsp_host_model_inst.xfer(8'hF1, 1'b1, rx, ka);
		chk("addr ack", 8'h00, {7'h00, ka});
		chk("busy", 8'h01, {7'h00, o_busy});
		for (int k = 0; k < n; k++) begin
			v = (k % 4 < 2) ? {1'b0, p} : {1'b0, t};
			q.push_back((k % 2 == 0) ? v[15:8] : v[7:0]);
		end
		for (int k = 0; k < n; k++) begin
			prsp_host_model_inst.xfer(8'hFF, k == n - 1, rx, ka);
			chk("data byte", q.pop_front(), rx);
		end
	endtask
	task automatic deaf(input logic [7:0] a);
		prsp_host_model_inst.start();
		prsp_host_model_inst.xfer(a, 1'b1, rx, ka);
		chk("foreign nack", 8'h01, {7'h00, ka});
		chk("not selected", 8'h00, {7'h00, o_selected});
	endtask
	function automatic logic [31:0] nx(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	initial begin
		repeat (12) @(posedge i_clk);
		@(negedge i_clk) i_resetn = 1'b1;
		repeat (10) @(negedge i_clk);
		chk("idle pins", 8'h03, {3'h0, o_scl, o_sda, o_busy, o_sda_oe, o_scl_oe});
		for (int j = 0; j < 3; j++) begin
			lf = nx(lf);
			p = lf[14:0];
			lf = nx(lf);
			t = lf[14:0];
			repeat (3 * RC) @(negedge i_clk);
			rd(4 + 2 * j);
			prsp_host_model_inst.stop();
			chk("free", 8'h00, {6'h00, o_busy, o_selected});
		end
		// Write to own address, read two near addresses, then repeated starts
		deaf(8'hF0);
		deaf(8'hF3);
		deaf(8'h71);
		rd(2);
		rd(3);
		prsp_host_model_inst.stop();
		chk("free", 8'h00, {6'h00, o_busy, o_selected});
		finish_test();
	end
	// Whole run needs about 12000 cycles
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_errors++;
			finish_test();
		end
	end
	// Refresh strobe spacing, counted on the falling edge where it is settled
	int          tick_gap = 0;
	always @(negedge i_clk) begin
		if (tick) begin
			if (tick_gap > 0)
				chk("tick period", 8'(RC), 8'(tick_gap));
			tick_gap = 1;
		end else if (tick_gap > 0) begin
			tick_gap++;
		end
	end
endmodule // testbench
bind prsp_target prsp_target_asserts prsp_target_asserts_inst (.i_clk, .i_resetn, .i_scl,
	.i_sda, .o_scl_oe, .o_sda, .o_sda_oe, .o_busy, .o_selected, .o_sample_tick);
